//--- pkg/acid_pkg.sv
package acid_pkg;

  // register byte offsets on the avalon word bus
  localparam logic [3:0] AUX_CONTROL_OFS  = 4'h0;
  localparam logic [3:0] CORE_ID_BASE_OFS = 4'h4;
  localparam int         ADDR_W           = 4;

  // aux_control field positions
  localparam int EXT_EXCL_ALL_BIT    = 29;
  localparam int TRACE_FLUSH_DIS_BIT = 12;
  localparam int FP_EXC_OUT_DIS_BIT  = 10;
  localparam int FP_OOO_DIS_BIT      = 9;
  localparam int DUAL_ISSUE_DIS_BIT  = 2;
  localparam int MCYC_INT_DIS_BIT    = 0;

  // writable bits of aux_control; reserved bits store nothing
  localparam logic [31:0] AUX_CONTROL_MASK  = 32'h2000_1605;
  localparam logic [31:0] AUX_CONTROL_RESET = 32'h0000_0000;

  // core_id_base field positions
  localparam int ID_IMPL_LSB  = 24;
  localparam int ID_VAR_LSB   = 20;
  localparam int ID_CONST_LSB = 16;
  localparam int ID_PART_LSB  = 4;
  localparam int ID_REV_LSB   = 0;
  localparam logic [3:0] ID_CONST_VALUE = 4'hf;

  // read answers one cycle after the request is seen
  localparam int READ_LATENCY = 1;

  typedef struct packed {
    logic ext_excl_all;
    logic trace_flush_dis;
    logic fp_exc_out_dis;
    logic fp_ooo_dis;
    logic dual_issue_dis;
    logic mcyc_int_dis;
  } acid_ctrl_s;

endpackage : acid_pkg

//--- src/acid_core_aux_control.sv
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
// Operation
// - ext-exclusive-all 0: exclusive flag and okay only on shareable address
// - ext-exclusive-all 1: every exclusive access flagged, okay response used
// - trace flush disable 1: flush valid ignored, flush ready held high
// - fp exception output disable 1: floating-point exception outputs suppressed
// - fp out-of-order disable 1: fp instructions complete in order
// - dual issue disable 1: one instruction issued at a time
// - multicycle interrupt disable 1: multi-cycle ops finish before stacking
// - id register read-only: implementer, constant 0xf, part number
// - id register holds variant in 23:20 and revision in 3:0
// - one id copy, same from secure and nonsecure state
// - aux control keeps separate secure and nonsecure copies
module acid_core_aux_control
  import acid_pkg::*;
#(
  parameter logic [7:0]  IMPLEMENTER = 8'h5a,  // arbitrary value
  parameter logic [3:0]  VARIANT     = 4'h0,
  parameter logic [11:0] PART_NUMBER = 12'h123, // arbitrary value
  parameter logic [3:0]  REVISION    = 4'h0
)(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  input  wire logic              avs_secure,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  output logic [1:0]             avs_response,
  input  wire logic              excl_req,
  input  wire logic              addr_shareable,
  input  wire logic              excl_okay_in,
  input  wire logic              trace_flush_valid,
  input  wire logic [4:0]        fp_exc_in,
  output logic                   ext_exclusive,
  output logic                   excl_okay,
  output logic                   trace_flush_ready,
  output logic                   trace_flush_take,
  output logic [4:0]             fp_exc_out,
  output logic                   fp_in_order,
  output logic                   single_issue,
  output logic                   mcyc_no_interrupt,
  output logic [31:0]            aux_control_s,
  output logic [31:0]            aux_control_ns
);

  logic [31:0] aux_sec_ff;
  logic [31:0] aux_nsec_ff;
  logic        ack_ff;
  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  resp_ff;
  logic        excl_ff;
  logic        okay_ff;
  logic        afready_ff;
  logic        aftake_ff;
  logic [4:0]  fpexc_ff;
  logic        inord_ff;
  logic        single_ff;
  logic        mcyc_ff;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  function automatic acid_ctrl_s ctrl_of(input logic [31:0] r);
    ctrl_of.ext_excl_all    = r[EXT_EXCL_ALL_BIT];
    ctrl_of.trace_flush_dis = r[TRACE_FLUSH_DIS_BIT];
    ctrl_of.fp_exc_out_dis  = r[FP_EXC_OUT_DIS_BIT];
    ctrl_of.fp_ooo_dis      = r[FP_OOO_DIS_BIT];
    ctrl_of.dual_issue_dis  = r[DUAL_ISSUE_DIS_BIT];
    ctrl_of.mcyc_int_dis    = r[MCYC_INT_DIS_BIT];
  endfunction : ctrl_of

  // the bus request is taken at the edge where waitrequest is high
  wire         req        = (avs_read | avs_write) & ~ack_ff;
  wire         hit_aux    = (avs_address == AUX_CONTROL_OFS);
  wire         hit_id     = (avs_address == CORE_ID_BASE_OFS);
  // the write lands at the edge where the master sees waitrequest low
  wire         wr_aux     = ack_ff & avs_write & hit_aux;
  wire         wr_sec     = wr_aux & avs_secure;
  wire         wr_nsec    = wr_aux & ~avs_secure;
  wire [31:0]  wmask      = lane_mask(avs_byteenable) & AUX_CONTROL_MASK;
  wire [31:0]  cur_aux    = avs_secure ? aux_sec_ff : aux_nsec_ff;
  wire [31:0]  nxt_sec    = (aux_sec_ff & ~wmask) | (avs_writedata & wmask);
  wire [31:0]  nxt_nsec   = (aux_nsec_ff & ~wmask) | (avs_writedata & wmask);
  // one copy, independent of security state
  wire [31:0]  id_word    = {IMPLEMENTER, VARIANT, ID_CONST_VALUE,
                             PART_NUMBER, REVISION};
  wire [31:0]  nxt_rdata  = !avs_read ? 32'h0000_0000 :
                            hit_aux ? cur_aux :
                            hit_id  ? id_word : 32'h0000_0000;
  // unmapped addresses answer slave error; id writes are ignored
  wire [1:0]   nxt_resp   = (hit_aux | hit_id) ? 2'h0 : 2'h2;

  // the running behaviour follows the copy of the state being executed in
  wire acid_ctrl_s ctl    = ctrl_of(avs_secure ? aux_sec_ff : aux_nsec_ff);

  // reserved bits are masked so software writes there have no effect
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      aux_sec_ff  <= AUX_CONTROL_RESET;
      aux_nsec_ff <= AUX_CONTROL_RESET;
    end
    else if (clk_en)
    begin
      if (wr_sec)
        aux_sec_ff <= nxt_sec;
      if (wr_nsec)
        aux_nsec_ff <= nxt_nsec;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ack_ff   <= 1'b0;
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      resp_ff  <= 2'h0;
    end
    else if (clk_en)
    begin
      ack_ff   <= req;
      wait_ff  <= ~req;
      rdata_ff <= req ? nxt_rdata : 32'h0000_0000;
      resp_ff  <= req ? nxt_resp : 2'h0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      excl_ff    <= 1'b0;
      okay_ff    <= 1'b0;
      afready_ff <= 1'b1;
      aftake_ff  <= 1'b0;
      fpexc_ff   <= 5'h00;
      inord_ff   <= 1'b0;
      single_ff  <= 1'b0;
      mcyc_ff    <= 1'b0;
    end
    else if (clk_en)
    begin
      excl_ff    <= excl_req & (addr_shareable | ctl.ext_excl_all);
      okay_ff    <= excl_req & (addr_shareable | ctl.ext_excl_all)
                    & excl_okay_in;
      afready_ff <= ctl.trace_flush_dis | trace_flush_valid;
      aftake_ff  <= trace_flush_valid & ~ctl.trace_flush_dis;
      fpexc_ff   <= ctl.fp_exc_out_dis ? 5'h00 : fp_exc_in;
      inord_ff   <= ctl.fp_ooo_dis;
      single_ff  <= ctl.dual_issue_dis;
      mcyc_ff    <= ctl.mcyc_int_dis;
    end
  end

  assign avs_waitrequest   = wait_ff;
  assign avs_readdata      = rdata_ff;
  assign avs_response      = resp_ff;
  assign ext_exclusive     = excl_ff;
  assign excl_okay         = okay_ff;
  assign trace_flush_ready = afready_ff;
  assign trace_flush_take  = aftake_ff;
  assign fp_exc_out        = fpexc_ff;
  assign fp_in_order       = inord_ff;
  assign single_issue      = single_ff;
  assign mcyc_no_interrupt = mcyc_ff;
  assign aux_control_s     = aux_sec_ff;
  assign aux_control_ns    = aux_nsec_ff;

endmodule : acid_core_aux_control

//--- tb/acid_core_aux_control_monitor.sv
`timescale 1ns/1ps
module acid_aux_monitor
  import acid_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_secure,
  input wire logic        avs_waitrequest,
  input wire logic        excl_req,
  input wire logic        addr_shareable,
  input wire logic        excl_okay_in,
  input wire logic        trace_flush_valid,
  input wire logic [4:0]  fp_exc_in,
  input wire logic        ext_exclusive,
  input wire logic        excl_okay,
  input wire logic        trace_flush_ready,
  input wire logic        trace_flush_take,
  input wire logic [4:0]  fp_exc_out,
  input wire logic        fp_in_order,
  input wire logic        single_issue,
  input wire logic        mcyc_no_interrupt,
  input wire logic [31:0] aux_control_s,
  input wire logic [31:0] aux_control_ns
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // outputs are only judged after an edge that ran outside reset
  logic        run_ff;
  wire  [31:0] cfg = avs_secure ? aux_control_s : aux_control_ns;
  wire         xq  = excl_req & (addr_shareable | cfg[EXT_EXCL_ALL_BIT]);
  always_ff @(posedge ref_clk) run_ff <= clk_en & ~reset;
  sequence taken_q;
    clk_en && (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence answer_q;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_excl_flag: assert property (run_ff |-> ext_exclusive == $past(xq))
    else $error("exclusive flag wrong");
  a_excl_okay: assert property (run_ff |-> excl_okay ==
    $past(xq & excl_okay_in)) else $error("exclusive okay wrong");
  a_flush_ready: assert property (run_ff |-> trace_flush_ready ==
    $past(cfg[12] | trace_flush_valid)) else $error("flush ready wrong");
  a_flush_take: assert property (run_ff |-> trace_flush_take ==
    $past(~cfg[12] & trace_flush_valid)) else $error("flush take wrong");
  a_fp_exc: assert property (run_ff |-> fp_exc_out ==
    ($past(cfg[10]) ? 5'h00 : $past(fp_exc_in))) else $error("fp exc wrong");
  a_core_bits: assert property (run_ff |->
    {fp_in_order, single_issue, mcyc_no_interrupt} == $past({cfg[9], cfg[2],
    cfg[0]})) else $error("core control bits wrong");
  a_bus_answer: assert property (taken_q |=> answer_q)
    else $error("bus answer not one cycle");
  a_reserved_zero: assert property (((aux_control_s | aux_control_ns) &
    ~AUX_CONTROL_MASK) == 32'h0) else $error("reserved bit stored");
endmodule : acid_aux_monitor
bind acid_core_aux_control acid_aux_monitor mon_u (.*);

//--- tb/tb_acid_core_aux_control.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module tb_acid_core_aux_control import acid_pkg::*;;
  logic ref_clk = 0, reset = 1, clk_en = 1, avs_read = 0, avs_write = 0;
  logic avs_secure = 0, excl_req = 0, addr_shareable = 0, excl_okay_in = 0;
  logic trace_flush_valid = 0, avs_waitrequest, ext_exclusive, excl_okay;
  logic trace_flush_ready, trace_flush_take, fp_in_order, single_issue;
  logic mcyc_no_interrupt;
  logic [ADDR_W-1:0] avs_address = 4'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [4:0]  fp_exc_in = 5'h00, fp_exc_out;
  logic [1:0]  avs_response, rs;
  logic [31:0] avs_writedata = 0, avs_readdata, aux_control_s, aux_control_ns;
  logic [31:0] rd;
  int          num_errors = 0, n_checks = 0, cyc = 0;
  acid_core_aux_control dut_u (.*);
  always #5 ref_clk = ~ref_clk;
  // entered just after an edge; holds the request until waitrequest is low
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rs = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask : acc
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      complete_run();
    end
  end
  initial
  begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    acc(1'b0, CORE_ID_BASE_OFS, 32'h0);
    `CHK(rd, 32'h5a0f_1230)
    avs_secure <= 1'b1;
    acc(1'b1, CORE_ID_BASE_OFS, 32'hffff_ffff);
    acc(1'b0, CORE_ID_BASE_OFS, 32'h0);
    `CHK(rd, 32'h5a0f_1230)
    $display("id test done");
    acc(1'b1, AUX_CONTROL_OFS, 32'hffff_ffff);
    acc(1'b0, AUX_CONTROL_OFS, 32'h0);
    `CHK(rd, 32'h2000_1605)
    `CHK(aux_control_ns, 32'h0)
    avs_secure <= 1'b0;
    acc(1'b1, AUX_CONTROL_OFS, 32'h0000_0004);
    acc(1'b0, AUX_CONTROL_OFS, 32'h0);
    `CHK(rd, 32'h0000_0004)
    `CHK(aux_control_s, 32'h2000_1605)
    $display("bank test done");
    excl_req <= 1'b1;
    excl_okay_in <= 1'b1;
    trace_flush_valid <= 1'b1;
    fp_exc_in <= 5'h15;
    repeat (2) @(posedge ref_clk);
    #1 `CHK({ext_exclusive, trace_flush_take, single_issue}, 3'b011)
    `CHK(fp_exc_out, 5'h15)
    @(posedge ref_clk);
    avs_secure <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 `CHK({ext_exclusive, excl_okay, trace_flush_take}, 3'b110)
    `CHK({fp_exc_out, fp_in_order, mcyc_no_interrupt}, 7'h03)
    $display("control test done");
    @(posedge ref_clk);
    acc(1'b0, 4'h8, 32'h0);
    `CHK({rs, rd}, {2'b10, 32'h0})
    $display("unmapped test done");
    avs_secure <= 1'b0;
    trace_flush_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 `CHK({trace_flush_ready, fp_exc_out}, 6'h15)
    @(posedge ref_clk);
    clk_en <= 1'b0;
    fp_exc_in <= 5'h0a;
    repeat (2) @(posedge ref_clk);
    #1 `CHK(fp_exc_out, 5'h15)
    @(posedge ref_clk);
    clk_en <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 `CHK(fp_exc_out, 5'h0a)
    $display("enable test done");
    @(posedge ref_clk);
    complete_run();
  end
endmodule : tb_acid_core_aux_control
